/* File: hw/mcs_timing_regs.vh */
// constants for the machine cycle sequencer and external data move stretch
`ifndef MCS_TIMING_REGS_VH
`define MCS_TIMING_REGS_VH

// states per machine cycle
`define MCS_STATES_PER_CYCLE   3'h4
// stretch field position in the bus timing control value
`define MCS_STRETCH_MSB        2
`define MCS_STRETCH_LSB        0
`define MCS_STRETCH_RESET      3'h1
// external data move opcodes
`define MCS_OP_XMOVE_RD_DPTR   8'he0
`define MCS_OP_XMOVE_RD_RI0    8'he2
`define MCS_OP_XMOVE_RD_RI1    8'he3
`define MCS_OP_XMOVE_WR_DPTR   8'hf0
`define MCS_OP_XMOVE_WR_RI0    8'hf2
`define MCS_OP_XMOVE_WR_RI1    8'hf3
// compare-and-branch against immediate, registers two to seven
`define MCS_OP_CMPBR_R2        8'hba
`define MCS_OP_CMPBR_R7        8'hbf
// strobe low time in clocks for stretch zero, then four clocks per step
`define MCS_STROBE_BASE        5'h2
`define MCS_STROBE_STEP        5'h4
// strobe opens at this state of the access cycle and closes at the same offset, or two clocks after opening (two clocks earlier) at stretch zero
`define MCS_STROBE_OPEN_STATE  4'h2

`endif

/* File: hw/mcs_cycle_decode.v */
// opcode to machine cycle count decoder for the full 256 entry opcode space
`include "mcs_timing_regs.vh"

module mcs_cycle_decode (
    input  wire [7:0] i_opcode,
    output reg  [2:0] o_cycles,
    output reg        o_xmove,
    output reg        o_xmove_wr
);
    always @* begin
        o_xmove    = 1'b0;
        o_xmove_wr = 1'b0;
        o_cycles   = 3'h1;
        // decoder covers all opcodes; half of them run in one cycle
        casez (i_opcode)
            8'he0, 8'he2, 8'he3: begin
                o_xmove  = 1'b1;
                o_cycles = 3'h2;
            end
            8'hf0, 8'hf2, 8'hf3: begin
                o_xmove    = 1'b1;
                o_xmove_wr = 1'b1;
                o_cycles   = 3'h2;
            end
            8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9,
            8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
            8'h12, 8'h02, 8'h20, 8'h30, 8'h10, 8'hd5:
                o_cycles = 3'h4;
            8'h?1, 8'h80, 8'h60, 8'h70, 8'h40, 8'h50, 8'hd8, 8'hd9, 8'hda,
            8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf:
                o_cycles = 3'h3;
            8'h22, 8'h32, 8'h73, 8'hc5, 8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0,
            8'h72, 8'ha0, 8'ha2, 8'h92, 8'h74, 8'h24, 8'h25, 8'h34,
            8'h35, 8'h94, 8'h95, 8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65,
            8'h42, 8'h52, 8'h62, 8'h43, 8'h53, 8'h63, 8'h85, 8'h86, 8'h87,
            8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'ha6,
            8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'haf,
            8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e,
            8'h7f, 8'hf5, 8'he5, 8'h93, 8'h83, 8'h84, 8'ha4, 8'hc0, 8'hd0,
            8'h05, 8'h15:
                o_cycles = 3'h2;
            8'h90, 8'h75:
                o_cycles = 3'h3;
            default:
                o_cycles = 3'h1;
        endcase
    end
endmodule

/* File: hw/mcs_sequencer.v */
// machine cycle sequencer with stretchable external data move
`include "mcs_timing_regs.vh"

module mcs_sequencer (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire [7:0] i_opcode,
    input  wire       i_fetch_ack,
    input  wire [7:0] i_bus_timing_control_wdata,
    input  wire       i_bus_timing_control_we,
    output reg  [3:0] o_state,
    output reg        o_fetch,
    output reg        o_instr_done,
    output reg        o_cpu_hold,
    output reg        o_xaddr_en,
    output reg        o_rd_n,
    output reg        o_wr_n,
    output reg  [2:0] o_stretch,
    output reg  [3:0] o_mcycle,
    output reg  [3:0] o_len
);
    localparam ST_ONE   = 4'b0001;
    localparam ST_TWO   = 4'b0010;
    localparam ST_THREE = 4'b0100;
    localparam ST_FOUR  = 4'b1000;

    reg  [3:0] state_ff;
    reg  [3:0] nxt_state;
    reg  [2:0] stretch_ff;
    reg  [2:0] xstretch_ff;
    reg  [3:0] mcycle_ff;
    reg  [3:0] len_ff;
    reg        xmove_ff;
    reg        xmove_wr_ff;
    reg        busy_ff;
    reg  [4:0] strobe_cnt_ff;
    reg        strobe_on_ff;
    reg        neg_phase_ff;
    wire [2:0] dec_cycles;
    wire       dec_xmove;
    wire       dec_xmove_wr;
    wire       last_state;
    wire       last_cycle;
    wire [4:0] strobe_len;
    wire       strobe_start;

    mcs_cycle_decode u_decode (
        .i_opcode   (i_opcode),
        .o_cycles   (dec_cycles),
        .o_xmove    (dec_xmove),
        .o_xmove_wr (dec_xmove_wr)
    );

    always @* begin
        case (state_ff)
            ST_ONE:   nxt_state = ST_TWO;
            ST_TWO:   nxt_state = ST_THREE;
            ST_THREE: nxt_state = ST_FOUR;
            ST_FOUR:  nxt_state = ST_ONE;
            default:  nxt_state = ST_ONE;
        endcase
    end

    assign last_state = (state_ff == ST_FOUR);
    assign last_cycle = (mcycle_ff + 4'h1 >= len_ff);

    // two clocks at zero, else four per stretch step
    // uses the stretch latched at fetch: a field write during an access
    // must not pull the strobe away from the already fixed cycle count
    assign strobe_len = (xstretch_ff == 3'h0) ? `MCS_STROBE_BASE
                        : (`MCS_STROBE_STEP * {2'h0, xstretch_ff});

    // access opens in the cycle after the opcode fetch
    assign strobe_start = busy_ff && xmove_ff && (mcycle_ff == 4'h1)
                          && (state_ff == ST_TWO);

    // falling edge phase marker, kept for half-state timing
    always @(negedge i_clk) begin
        if (i_srst) begin
            neg_phase_ff <= 1'b0;
        end else begin
            neg_phase_ff <= ~neg_phase_ff;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            state_ff      <= ST_ONE;
            stretch_ff    <= `MCS_STRETCH_RESET;
            xstretch_ff   <= `MCS_STRETCH_RESET;
            mcycle_ff     <= 4'h0;
            len_ff        <= 4'h1;
            xmove_ff      <= 1'b0;
            xmove_wr_ff   <= 1'b0;
            busy_ff       <= 1'b0;
            strobe_cnt_ff <= 5'h0;
            strobe_on_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // stretch field from bus timing control bits 2..0
            if (i_bus_timing_control_we) begin
                stretch_ff <= i_bus_timing_control_wdata[`MCS_STRETCH_MSB:`MCS_STRETCH_LSB];
            end
            // one opcode taken per cycle, at state_one
            if (state_ff == ST_ONE && !busy_ff && i_fetch_ack) begin
                busy_ff     <= 1'b1;
                mcycle_ff   <= 4'h0;
                xmove_ff    <= dec_xmove;
                xmove_wr_ff <= dec_xmove_wr;
                xstretch_ff <= stretch_ff;
                // external move length is stretch plus two
                // other lengths straight from the decoder
                if (dec_xmove) begin
                    len_ff <= {1'b0, stretch_ff} + 4'h2;
                end else begin
                    len_ff <= {1'b0, dec_cycles};
                end
                if (!dec_xmove && dec_cycles == 3'h1) begin
                    busy_ff <= 1'b0;
                end
            end else if (busy_ff && last_state) begin
                if (last_cycle) begin
                    busy_ff <= 1'b0;
                end else begin
                    mcycle_ff <= mcycle_ff + 4'h1;
                end
            end
            if (strobe_start) begin
                strobe_on_ff  <= 1'b1;
                strobe_cnt_ff <= strobe_len - 5'h1;
            end else if (strobe_on_ff) begin
                if (strobe_cnt_ff == 5'h0) begin
                    strobe_on_ff <= 1'b0;
                end else begin
                    strobe_cnt_ff <= strobe_cnt_ff - 5'h1;
                end
            end
        end
    end

    // registered outputs
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_state      <= ST_ONE;
            o_fetch      <= 1'b0;
            o_instr_done <= 1'b0;
            o_cpu_hold   <= 1'b0;
            o_xaddr_en   <= 1'b0;
            o_rd_n       <= 1'b1;
            o_wr_n       <= 1'b1;
            o_stretch    <= `MCS_STRETCH_RESET;
            o_mcycle     <= 4'h0;
            o_len        <= 4'h1;
        end else begin
            o_state      <= state_ff;
            o_fetch      <= (state_ff == ST_ONE) && !busy_ff;
            o_instr_done <= last_state && (!busy_ff || last_cycle);
            // core held only during stretched cycles of external move
            o_cpu_hold   <= busy_ff && xmove_ff && (mcycle_ff >= 4'h2);
            o_xaddr_en   <= busy_ff && xmove_ff && (mcycle_ff != 4'h0);
            o_rd_n       <= ~(strobe_on_ff && !xmove_wr_ff);
            o_wr_n       <= ~(strobe_on_ff && xmove_wr_ff);
            o_stretch    <= stretch_ff;
            o_mcycle     <= mcycle_ff;
            o_len        <= len_ff;
        end
    end
endmodule

/* File: sim/mcs_sequencer_chk.sv */
// checker for the sequencer's state, fetch, hold and strobe outputs
module mcs_sequencer_chk (
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic [3:0] o_state,
    input wire logic       o_fetch,
    input wire logic       o_cpu_hold,
    input wire logic       o_xaddr_en,
    input wire logic       o_rd_n,
    input wire logic       o_wr_n,
    input wire logic [2:0] o_stretch,
    input wire logic [3:0] o_mcycle,
    input wire logic [3:0] o_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] low_ff;
    logic [2:0] cyc_stretch_ff;
    // stretch in force for the instruction just fetched; later writes apply to the next one
    always_ff @(posedge i_clk) begin
        if (i_srst) cyc_stretch_ff <= 3'h1;
        else if (o_fetch) cyc_stretch_ff <= o_stretch;
    end
    wire        strb_n = o_rd_n & o_wr_n;
    // low time count, cleared while both strobes idle
    always_ff @(posedge i_clk) low_ff <= (i_srst | strb_n) ? 5'h0 : low_ff + 5'h1;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_next_state;
        o_state == ($past(o_state) << 1);
    endsequence
    sequence s_hold_cycle;
        o_cpu_hold [*4];
    endsequence
    a_state_onehot: assert property ($onehot(o_state))
        else $error("state not one-hot");
    a_state_order: assert property (!$past(i_srst) && o_state != 4'h8 |=> s_next_state)
        else $error("state out of order");
    a_state_wrap: assert property (o_state == 4'h8 |=> o_state == 4'h1)
        else $error("state four not followed by one");
    a_fetch_once: assert property (o_fetch |-> o_state == 4'h1 ##1 !o_fetch [*3])
        else $error("fetch outside state one or repeated");
    a_hold_span: assert property ($rose(o_cpu_hold) |-> s_hold_cycle)
        else $error("hold shorter than a machine cycle");
    a_hold_xmove: assert property (o_cpu_hold |-> o_xaddr_en && !o_fetch)
        else $error("hold outside an external move");
    a_xmove_len: assert property (o_xaddr_en |-> o_len == {1'b0, cyc_stretch_ff} + 4'h2)
        else $error("external move length wrong");
    a_strobe_width: assert property ($rose(strb_n) |->
        low_ff == ((cyc_stretch_ff == 3'h0) ? 5'h2 : {cyc_stretch_ff, 2'h0}))
        else $error("strobe width wrong");
    a_mcycle_range: assert property (o_xaddr_en |-> o_mcycle != 4'h0 && o_mcycle < o_len)
        else $error("access cycle index out of range");
    a_strobe_addr: assert property (!strb_n |-> o_xaddr_en)
        else $error("strobe outside access cycle");
endmodule

bind mcs_sequencer mcs_sequencer_chk u_chk (.i_clk, .i_srst, .o_state, .o_fetch, .o_cpu_hold,
    .o_xaddr_en, .o_rd_n, .o_wr_n, .o_stretch, .o_mcycle, .o_len);

/* File: sim/mcs_xmem_model.sv */
// external data memory that needs a fixed access time under the strobe
module mcs_xmem_model #(parameter int ACCESS = 2) (
    input  wire logic       i_clk,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    output logic      [7:0] o_served
);
    timeunit 1ns;
    timeprecision 1ns;
    int busy = 0;
    initial o_served = 8'h0;
    // an access counts only once the strobe has lasted the access time
    always @(posedge i_clk) begin
        if (i_rd_n & i_wr_n) busy = 0;
        else busy++;
        if (busy == ACCESS) o_served <= o_served + 8'h1;
    end
endmodule

/* File: sim/mcs_sequencer_test.sv */
// self-checking bench for the machine cycle sequencer
module mcs_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_clk = 1'b0;
    logic       i_srst = 1'b1;
    logic       i_fetch_ack = 1'b1;
    logic       we = 1'b0;
    logic [7:0] wdata = 8'h0;
    logic [7:0] i_opcode = 8'h0;
    wire        o_instr_done, o_rd_n, o_wr_n;
    wire  [2:0] o_stretch;
    wire  [7:0] fast_n, slow_n;
    int         bad_count = 0;
    int         cmp_count = 0;
    logic [7:0] xops [6] = '{8'he0, 8'hf0, 8'he2, 8'hf2, 8'he3, 8'hf3};

    mcs_sequencer u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_opcode(i_opcode),
        .i_fetch_ack(i_fetch_ack), .i_bus_timing_control_wdata(wdata),
        .i_bus_timing_control_we(we), .o_state(), .o_fetch(), .o_instr_done(o_instr_done),
        .o_cpu_hold(), .o_xaddr_en(), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
        .o_stretch(o_stretch), .o_mcycle(), .o_len());
    mcs_xmem_model #(.ACCESS(1)) u_fast (.i_clk(i_clk), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
        .o_served(fast_n));
    mcs_xmem_model #(.ACCESS(8)) u_slow (.i_clk(i_clk), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
        .o_served(slow_n));

    always #20 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic set_stretch(input logic [2:0] s);
        @(posedge i_clk);
        we <= 1'b1;
        wdata <= {5'h0, s};
        @(posedge i_clk);
        we <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk(o_stretch, s);
    endtask

    // one instruction measured from one completion to the next
    task automatic run(input logic [7:0] op, input int ncl, input int nst);
        int n;
        int s;
        logic [7:0] f0, s0;
        i_opcode <= op;
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (o_instr_done !== 1'b1 && n < 100);
        f0 = fast_n;
        s0 = slow_n;
        n = 0;
        s = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
            if (!(o_rd_n & o_wr_n)) s++;
        end while (o_instr_done !== 1'b1 && n < 100);
        chk(n, ncl);
        chk(s, nst);
        chk(fast_n - f0, nst > 0);
        chk(slow_n - s0, nst >= 8);
    endtask

    task automatic t_default();
        #1 chk(o_stretch, 3'h1);
        run(8'he0, 12, 4);
    endtask

    task automatic t_sweep();
        for (int s = 0; s < 8; s++) begin
            set_stretch(s[2:0]);
            run(xops[s % 6], 4 * (s + 2), (s == 0) ? 2 : 4 * s);
        end
    endtask

    task automatic t_cmpbr();
        for (int i = 0; i < 6; i++) run(8'hba + i[7:0], 16, 0);
    endtask

    task automatic t_rereset();
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        #1 chk(o_stretch, 3'h1);
    endtask

    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        t_default();
        t_sweep();
        t_cmpbr();
        t_rereset();
        run(8'hf0, 12, 4);
        end_sim();
    end
endmodule
